// ===== include/pcn_pkg.sv
`default_nettype none
package pcn_pkg;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int unsigned NPIN        = 10;      // Pins in the bank
   localparam int unsigned AW          = 8;       // Byte address width
   localparam int unsigned DW          = 32;      // Bus data width

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_DIR      = 6'h0D;   // pin_direction
   localparam logic [5:0] IDX_SET      = 6'h0E;   // pin_output_set
   localparam logic [5:0] IDX_CLR      = 6'h0F;   // pin_output_clear
   localparam logic [5:0] IDX_LEVEL    = 6'h10;   // pin_level
   localparam logic [5:0] IDX_MASK     = 6'h11;   // pin_change_notify_mask
   localparam logic [5:0] IDX_PKTCTL   = 6'h12;   // notify_packet_control
   localparam logic [5:0] IDX_IRQ_STAT = 6'h20;   // Interrupt status (RO)
   localparam logic [5:0] IDX_IRQ_EN   = 6'h21;   // Interrupt enable (RW)
   localparam logic [5:0] IDX_IRQ_CLR  = 6'h22;   // Interrupt clear (WO)

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [9:0] DIR_RST      = 10'h000; // All pins inputs
   localparam logic [9:0] MASK_RST     = 10'h100; // Pin 8 masked
   localparam int unsigned PKT_VENDOR_BIT = 0;    // Vendor format select
   localparam int unsigned PKT_BRK_BIT    = 1;    // Break notify enable
   localparam int unsigned IRQ_CHG_BIT    = 0;    // Unmasked pin change
   localparam int unsigned IRQ_BRK_BIT    = 1;    // Break received
   localparam int unsigned IRQ_SENT_BIT   = 2;    // Packet delivered
   localparam int unsigned IRQ_W          = 3;    // Interrupt bits

   // ---------------------------------------------------------------
   // Notification packet constants
   // ---------------------------------------------------------------
   localparam logic [7:0] STD_REQ_TYPE = 8'hA1;   // In, class, interface
   localparam logic [7:0] STD_NOTIFY   = 8'h20;   // Serial state code
   localparam logic [15:0] STD_VALUE   = 16'h0000;
   localparam logic [15:0] STD_INDEX   = 16'h0000;
   localparam logic [15:0] STD_LENGTH  = 16'h0002;
   localparam logic [3:0] STD_BYTES    = 4'hA;    // Standard packet size
   localparam logic [3:0] VND_BYTES    = 4'h5;    // Vendor packet size
   // Packet sender states, Gray along idle -> send -> idle
   typedef enum logic [1:0] {
      PCN_IDLE = 2'b00,
      PCN_SEND = 2'b01
   } pcn_state_t;

endpackage
`default_nettype wire

// ===== core/pcn_pin_notify.sv
// What this block does
// - Direction bit one makes pin output; reset inputs.
// - Alternate-function pins ignore the direction register.
// - Set register drives marked output pins high.
// - Clear register drives marked output pins low.
// - Set/clear skip inputs and alternate pins; write-only.
// - Level register reads all ten pin levels.
// - Level write drives outputs to written values.
// - Unmasked input change sends packet; mask resets 0x100.
// - Masking covers alternate-function input pins too.
// - Masked pins still reported in reads, packets.
// - Break triggers packet only when enabled.
// - Format bit picks standard or vendor packet.
// - Standard packet: ten bytes with fixed header.
// - Standard data field carries serial line bits.
// - Vendor packet: states, change flags, error byte.
// - Reserved upper bits always read as zero.
// - Non-selected pins stay general purpose I/O.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module pcn_pin_notify (
   input  wire logic                    sys_clk,      // Core clock, 10 MHz
   input  wire logic                    rst,          // Synchronous reset
   input  wire logic                    wb_cyc_i,     // Bus cycle
   input  wire logic                    wb_stb_i,     // Bus strobe
   input  wire logic                    wb_we_i,      // Write enable
   input  wire logic [pcn_pkg::AW-1:0]  wb_adr_i,     // Byte address
   input  wire logic [3:0]              wb_sel_i,     // Byte lanes
   input  wire logic [pcn_pkg::DW-1:0]  wb_dat_i,     // Write data
   output logic      [pcn_pkg::DW-1:0]  wb_dat_o,     // Read data
   output logic                         wb_ack_o,     // Acknowledge
   input  wire logic [pcn_pkg::NPIN-1:0] pin_i,       // Pad levels
   output logic      [pcn_pkg::NPIN-1:0] pin_o,       // Pad output values
   output logic      [pcn_pkg::NPIN-1:0] pin_oe,      // Pad output enables
   input  wire logic [pcn_pkg::NPIN-1:0] alt_sel_i,   // Pin taken by alternate
   input  wire logic [pcn_pkg::NPIN-1:0] alt_o_i,     // Alternate output value
   input  wire logic [pcn_pkg::NPIN-1:0] alt_oe_i,    // Alternate output enable
   input  wire logic                    brk_evt_i,    // Break received pulse
   input  wire logic                    ovr_evt_i,    // Overrun pulse
   input  wire logic                    par_evt_i,    // Parity error pulse
   input  wire logic                    frm_evt_i,    // Framing error pulse
   input  wire logic                    ring_i,       // Ring level
   input  wire logic                    dsr_i,        // Data set ready level
   input  wire logic                    dcd_i,        // Carrier detect level
   output logic                         pkt_valid_o,  // Packet byte valid
   output logic      [7:0]              pkt_data_o,   // Packet byte
   output logic                         pkt_last_o,   // Last byte of packet
   input  wire logic                    pkt_ready_i,  // Endpoint takes byte
   output logic                         irq_o         // Level interrupt
);
   import pcn_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [NPIN-1:0]   dir_q;        // Direction, one = output
   logic [NPIN-1:0]   out_q;        // General purpose output values
   logic [NPIN-1:0]   mask_q;       // Change notify mask
   logic [1:0]        pktctl_q;     // Break enable, format select
   logic [NPIN-1:0]   prev_q;       // Pin levels one cycle ago
   logic [NPIN-1:0]   chg_q;        // Change flags since last packet
   logic [3:0]        err_q;        // Overrun, parity, framing, break
   logic              pend_q;       // Packet wanted
   logic [IRQ_W-1:0]  ists_q;       // Sticky interrupt status
   logic [IRQ_W-1:0]  ien_q;        // Interrupt enable
   pcn_state_t        state_q;      // Sender state
   logic [3:0]        idx_q;        // Byte index in packet
   logic [3:0]        len_q;        // Packet length latched at start
   logic              vnd_q;        // Format latched at start
   logic [NPIN-1:0]   snap_lvl_q;   // Pin levels captured at start
   logic [NPIN-1:0]   snap_chg_q;   // Change flags captured at start
   logic [3:0]        snap_err_q;   // Error bits captured at start
   logic [7:0]        data_q;       // Byte on the packet port
   logic              ack_q;        // Bus acknowledge
   logic [DW-1:0]     rdat_q;       // Bus read data

   logic              bus_req;      // New bus access this cycle
   logic              bus_wr;       // Write access
   logic [5:0]        bus_idx;      // Register index
   logic [15:0]       wdat;         // Low half of write data
   logic              wr_lo;        // Lane 0 written
   logic              wr_hi;        // Lane 1 written
   logic [NPIN-1:0]   gp_out;       // Pins that are general purpose outputs
   logic [NPIN-1:0]   in_pins;      // Pins currently not driven
   logic [NPIN-1:0]   chg_now;      // Unmasked change this cycle
   logic              brk_trig;     // Break that asks for a packet
   logic              start;        // Packet starts this cycle
   logic              take;         // Packet byte accepted
   logic              done;         // Last byte accepted
   logic [3:0]        err_now;      // Error events this cycle
   logic [IRQ_W-1:0]  ievt;         // Interrupt events this cycle

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
   assign bus_wr   = bus_req && wb_we_i;
   assign bus_idx  = wb_adr_i[7:2];
   assign wdat     = wb_dat_i[15:0];
   assign wr_lo    = wb_sel_i[0];
   assign wr_hi    = wb_sel_i[1];

   // ---------------------------------------------------------------
   // Pin muxing
   // ---------------------------------------------------------------
   // Alternate pins follow their function, the others stay GPIO
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         assign pin_o[g]  = alt_sel_i[g] ? alt_o_i[g]  : out_q[g];
         assign pin_oe[g] = alt_sel_i[g] ? alt_oe_i[g] : dir_q[g];
         assign gp_out[g] = dir_q[g] && !alt_sel_i[g];
      end
   endgenerate

   // Any pin not being driven counts as an input for change watch
   assign in_pins  = ~pin_oe;
   assign chg_now  = (pin_i ^ prev_q) & in_pins & ~mask_q;
   assign brk_trig = brk_evt_i && pktctl_q[PKT_BRK_BIT];
   assign err_now  = {ovr_evt_i, par_evt_i, frm_evt_i, brk_evt_i};

   // ---------------------------------------------------------------
   // Bus acknowledge and read data
   // ---------------------------------------------------------------
   // Every access, mapped or not, is acknowledged one cycle later
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   // Read mux; unmapped and write-only registers read zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdat_q <= '0;
      end else if (bus_req && !wb_we_i) begin
         rdat_q <= '0;
         case (bus_idx)
            IDX_DIR:      rdat_q[NPIN-1:0]  <= dir_q;
            IDX_LEVEL:    rdat_q[NPIN-1:0]  <= pin_i;
            IDX_MASK:     rdat_q[NPIN-1:0]  <= mask_q;
            IDX_PKTCTL:   rdat_q[1:0]       <= pktctl_q;
            IDX_IRQ_STAT: rdat_q[IRQ_W-1:0] <= ists_q;
            IDX_IRQ_EN:   rdat_q[IRQ_W-1:0] <= ien_q;
            default:      rdat_q <= '0;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Direction, mask and packet control; upper bits never stored
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dir_q    <= DIR_RST;
         mask_q   <= MASK_RST;
         pktctl_q <= 2'b00;
         ien_q    <= '0;
      end else if (bus_wr) begin
         case (bus_idx)
            IDX_DIR: begin
               if (wr_lo) dir_q[7:0] <= wdat[7:0];
               if (wr_hi) dir_q[9:8] <= wdat[9:8];
            end
            IDX_MASK: begin
               if (wr_lo) mask_q[7:0] <= wdat[7:0];
               if (wr_hi) mask_q[9:8] <= wdat[9:8];
            end
            IDX_PKTCTL: begin
               if (wr_lo) pktctl_q <= wdat[1:0];
            end
            IDX_IRQ_EN: begin
               if (wr_lo) ien_q <= wdat[IRQ_W-1:0];
            end
            default: begin
               // Other writes leave configuration alone
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output value register
   // ---------------------------------------------------------------
   // Only general purpose outputs move; a write landing on an input
   // is dropped rather than stored, so turning it to output later
   // shows the last value written while it was an output.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_q <= '0;
      end else if (bus_wr) begin
         case (bus_idx)
            IDX_SET: begin
               if (wr_lo) out_q[7:0] <= out_q[7:0] | (wdat[7:0] & gp_out[7:0]);
               if (wr_hi) out_q[9:8] <= out_q[9:8] | (wdat[9:8] & gp_out[9:8]);
            end
            IDX_CLR: begin
               if (wr_lo) out_q[7:0] <= out_q[7:0] & ~(wdat[7:0] & gp_out[7:0]);
               if (wr_hi) out_q[9:8] <= out_q[9:8] & ~(wdat[9:8] & gp_out[9:8]);
            end
            IDX_LEVEL: begin
               if (wr_lo) out_q[7:0] <= (out_q[7:0] & ~gp_out[7:0])
                                        | (wdat[7:0] & gp_out[7:0]);
               if (wr_hi) out_q[9:8] <= (out_q[9:8] & ~gp_out[9:8])
                                        | (wdat[9:8] & gp_out[9:8]);
            end
            default: begin
               // No output effect
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Change detection and event capture
   // ---------------------------------------------------------------
   // Previous level; reset value is zero so a high pin after reset
   // counts as a change once, which is the safe direction to err.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_q <= '0;
      end else begin
         prev_q <= pin_i;
      end
   end

   // Change flags; delivery clears only the flags the packet carried,
   // so a change seen mid-send on a pin the packet did not carry still goes out with the next packet
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chg_q <= '0;
      end else begin
         chg_q <= (done ? chg_q & ~snap_chg_q : chg_q) | chg_now;
      end
   end

   // Error bits held until a packet captures them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         err_q <= '0;
      end else begin
         err_q <= (start ? 4'h0 : err_q) | err_now;
      end
   end

   // Pending trigger; new trigger wins over the start that consumes it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= (pend_q && !start) || (|chg_now) || brk_trig;
      end
   end

   // ---------------------------------------------------------------
   // Packet sender
   // ---------------------------------------------------------------
   assign start = (state_q == PCN_IDLE) && pend_q;
   assign take  = (state_q == PCN_SEND) && pkt_ready_i;
   assign done  = take && (idx_q == len_q - 4'h1);

   // Byte at a given index of the captured packet
   function automatic logic [7:0] pkt_byte(
      input logic            vnd,
      input logic [3:0]      idx,
      input logic [NPIN-1:0] lvl,
      input logic [NPIN-1:0] chg,
      input logic [3:0]      err,
      input logic [2:0]      modem
   );
      logic [15:0] sdat;
      sdat = {9'h000, err[3], err[2], err[1], modem[2], err[0], modem[1], modem[0]};
      pkt_byte = 8'h00;
      if (vnd) begin
         case (idx)
            4'h0:    pkt_byte = lvl[7:0];
            4'h1:    pkt_byte = {6'h00, lvl[9:8]};
            4'h2:    pkt_byte = chg[7:0];
            4'h3:    pkt_byte = {6'h00, chg[9:8]};
            4'h4:    pkt_byte = {4'h0, err};
            default: pkt_byte = 8'h00;
         endcase
      end else begin
         case (idx)
            4'h0:    pkt_byte = STD_REQ_TYPE;
            4'h1:    pkt_byte = STD_NOTIFY;
            4'h2:    pkt_byte = STD_VALUE[7:0];
            4'h3:    pkt_byte = STD_VALUE[15:8];
            4'h4:    pkt_byte = STD_INDEX[7:0];
            4'h5:    pkt_byte = STD_INDEX[15:8];
            4'h6:    pkt_byte = STD_LENGTH[7:0];
            4'h7:    pkt_byte = STD_LENGTH[15:8];
            4'h8:    pkt_byte = sdat[7:0];
            4'h9:    pkt_byte = sdat[15:8];
            default: pkt_byte = 8'h00;
         endcase
      end
   endfunction

   // Sender state, index and snapshot; the snapshot keeps the bytes
   // steady while the endpoint stalls
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q    <= PCN_IDLE;
         idx_q      <= 4'h0;
         len_q      <= STD_BYTES;
         vnd_q      <= 1'b0;
         snap_lvl_q <= '0;
         snap_chg_q <= '0;
         snap_err_q <= '0;
         data_q     <= 8'h00;
      end else begin
         case (state_q)
            PCN_IDLE: begin
               if (start) begin
                  state_q    <= PCN_SEND;
                  idx_q      <= 4'h0;
                  vnd_q      <= pktctl_q[PKT_VENDOR_BIT];
                  len_q      <= pktctl_q[PKT_VENDOR_BIT] ? VND_BYTES : STD_BYTES;
                  snap_lvl_q <= pin_i;
                  snap_chg_q <= chg_q | chg_now;
                  snap_err_q <= err_q | err_now;
                  data_q     <= pkt_byte(pktctl_q[PKT_VENDOR_BIT], 4'h0, pin_i,
                                         chg_q | chg_now, err_q | err_now,
                                         {ring_i, dsr_i, dcd_i});
               end
            end
            PCN_SEND: begin
               if (done) begin
                  state_q <= PCN_IDLE;
                  idx_q   <= 4'h0;
               end else if (take) begin
                  idx_q  <= idx_q + 4'h1;
                  data_q <= pkt_byte(vnd_q, idx_q + 4'h1, snap_lvl_q, snap_chg_q,
                                     snap_err_q, {ring_i, dsr_i, dcd_i});
               end
            end
            default: begin
               state_q <= PCN_IDLE;
            end
         endcase
      end
   end

   assign pkt_valid_o = (state_q == PCN_SEND);
   assign pkt_data_o  = data_q;
   assign pkt_last_o  = (state_q == PCN_SEND) && (idx_q == len_q - 4'h1);

   // ---------------------------------------------------------------
   // Interrupt status
   // ---------------------------------------------------------------
   assign ievt[IRQ_CHG_BIT]  = |chg_now;
   assign ievt[IRQ_BRK_BIT]  = brk_evt_i;
   assign ievt[IRQ_SENT_BIT] = done;

   // Write-one-to-clear; an event in the clearing cycle stays set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ists_q <= '0;
      end else if (bus_wr && bus_idx == IDX_IRQ_CLR && wr_lo) begin
         ists_q <= (ists_q & ~wdat[IRQ_W-1:0]) | ievt;
      end else begin
         ists_q <= ists_q | ievt;
      end
   end

   assign irq_o = |(ists_q & ien_q);

endmodule

`default_nettype wire

// ===== tb/pcn_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pcn_sva (
   input wire logic                     sys_clk,     // Clock
   input wire logic                     rst,         // Reset
   input wire logic                     wb_cyc_i,    // Cycle
   input wire logic                     wb_stb_i,    // Strobe
   input wire logic                     wb_we_i,     // Write
   input wire logic [pcn_pkg::AW-1:0]   wb_adr_i,    // Address
   input wire logic [pcn_pkg::DW-1:0]   wb_dat_i,    // Write data
   input wire logic [pcn_pkg::DW-1:0]   wb_dat_o,    // Read data
   input wire logic                     wb_ack_o,    // Ack
   input wire logic [pcn_pkg::NPIN-1:0] pin_o,       // Pad value
   input wire logic [pcn_pkg::NPIN-1:0] pin_oe,      // Pad enable
   input wire logic [pcn_pkg::NPIN-1:0] alt_sel_i,   // Alt select
   input wire logic [pcn_pkg::NPIN-1:0] alt_o_i,     // Alt value
   input wire logic [pcn_pkg::NPIN-1:0] alt_oe_i,    // Alt enable
   input wire logic                     pkt_valid_o, // Byte valid
   input wire logic [7:0]               pkt_data_o,  // Byte
   input wire logic                     pkt_last_o,  // Last byte
   input wire logic                     pkt_ready_i, // Host ready
   input wire logic                     irq_o        // Interrupt
);
   import pcn_pkg::*;
   logic req;  // New request taken at this edge
   logic wset; // Set register written
   logic wclr; // Clear register written
   assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wset = req && wb_we_i && (wb_adr_i[7:2] == IDX_SET);
   assign wclr = req && wb_we_i && (wb_adr_i[7:2] == IDX_CLR);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_ack_answer: assert property (req |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_rsv_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:10] == 22'h0)
      else $error("reserved read bits not zero");
   // Alternate pins ignore every pin register
   a_alt_drive: assert property ((((pin_o ^ alt_o_i) | (pin_oe ^ alt_oe_i)) & alt_sel_i) == 10'h0)
      else $error("alternate pin not driven by alternate");
   a_set_high: assert property (wset |=> ($past(wb_dat_i[9:0]) & pin_oe & ~alt_sel_i & ~pin_o) == 10'h0)
      else $error("set left an output low");
   a_clr_low: assert property (wclr |=> ($past(wb_dat_i[9:0]) & pin_oe & ~alt_sel_i & pin_o) == 10'h0)
      else $error("clear left an output high");
   a_pkt_hold: assert property (pkt_valid_o && !pkt_ready_i |=> pkt_valid_o && $stable(pkt_data_o))
      else $error("packet byte dropped while stalled");
   a_last_valid: assert property (pkt_last_o && pkt_ready_i |=> !pkt_valid_o)
      else $error("packet ran past its last byte");
   c_pkt: cover property ($rose(pkt_valid_o));
   c_end: cover property (pkt_last_o && pkt_ready_i);
   c_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ===== tb/pcn_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcn_host_model (
   input  wire logic       sys_clk,   // Clock
   input  wire logic       rst,       // Reset
   input  wire logic       slow,      // Stall every other cycle
   input  wire logic       pkt_valid, // Byte offered
   input  wire logic [7:0] pkt_data,  // Byte
   output logic            pkt_ready  // Byte taken
);
   logic [7:0] got_q[$]; // Bytes received, oldest first
   logic       tick_q;   // Stall phase
   // A slow host takes a byte only every other cycle
   always @(posedge sys_clk) begin
      if (rst) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= ~tick_q;
         if (pkt_valid && pkt_ready) begin
            got_q.push_back(pkt_data);
         end
      end
   end
   assign pkt_ready = !slow || tick_q;
endmodule
`default_nettype wire

// ===== tb/pcn_pin_notify_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pcn_pin_notify_tb_top;
   import pcn_pkg::*;
   logic            sys_clk, rst;                              // Clock, reset
   logic            wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;     // Bus handshake
   logic [AW-1:0]   wb_adr_i;                                  // Address
   logic [3:0]      wb_sel_i;                                  // Lanes
   logic [DW-1:0]   wb_dat_i, wb_dat_o, rv;                    // Bus data
   logic [NPIN-1:0] pin_i, pin_o, pin_oe, alt_sel_i, alt_o_i, alt_oe_i; // Pads
   logic            brk_evt_i, ovr_evt_i, par_evt_i, frm_evt_i; // Events
   logic            ring_i, dsr_i, dcd_i, irq_o, slow;         // Levels
   logic            pkt_valid_o, pkt_last_o, pkt_ready_i;      // Packet port
   logic [7:0]      pkt_data_o;                                // Packet byte
   logic [7:0]      exp_q[$];                                  // Expected bytes
   int              fail_count, checked;                       // Counters
   pcn_pin_notify u_dut (
      .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe(pin_oe), .alt_sel_i(alt_sel_i), .alt_o_i(alt_o_i), .alt_oe_i(alt_oe_i),
      .brk_evt_i(brk_evt_i), .ovr_evt_i(ovr_evt_i), .par_evt_i(par_evt_i),
      .frm_evt_i(frm_evt_i), .ring_i(ring_i), .dsr_i(dsr_i), .dcd_i(dcd_i),
      .pkt_valid_o(pkt_valid_o), .pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o),
      .pkt_ready_i(pkt_ready_i), .irq_o(irq_o));
   pcn_host_model u_host (.sys_clk(sys_clk), .rst(rst), .slow(slow),
      .pkt_valid(pkt_valid_o), .pkt_data(pkt_data_o), .pkt_ready(pkt_ready_i));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One classic cycle; waits for ack, bounded by the watchdog
   task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, idx, 2'b00, d};
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      rv = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rdc(input logic [5:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk($sformatf("reg %h", idx), rv, e);
   endtask
   task automatic evt(input logic [3:0] m);
      @(posedge sys_clk);
      {brk_evt_i, ovr_evt_i, par_evt_i, frm_evt_i} <= m;
      @(posedge sys_clk);
      {brk_evt_i, ovr_evt_i, par_evt_i, frm_evt_i} <= 4'h0;
   endtask
   // Compare the host's bytes with the expected packet, then empty both
   task automatic chk_pkt();
      int i;
      i = 0;
      while (u_host.got_q.size() < exp_q.size() && i < 400) begin
         @(posedge sys_clk);
         i++;
      end
      chk("pkt len", u_host.got_q.size(), exp_q.size());
      foreach (exp_q[k]) if (k < u_host.got_q.size()) chk("pkt byte", u_host.got_q[k], exp_q[k]);
      u_host.got_q.delete();
      exp_q.delete();
   endtask
   task automatic nopkt();
      repeat (20) @(posedge sys_clk);
      chk("no pkt", u_host.got_q.size(), 0);
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Whole run needs about 200 cycles; allow 75 times that
   initial begin
      #1500000;
      fail_count++;
      give_verdict();
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, pin_i} = '0;
      {alt_sel_i, alt_o_i, alt_oe_i, brk_evt_i, ovr_evt_i, par_evt_i, frm_evt_i} = '0;
      {ring_i, dsr_i, dcd_i, slow, fail_count, checked} = '0;
      wb_sel_i = 4'hF;
      rst = 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(IDX_DIR, 32'h0);
      rdc(IDX_MASK, 32'h100);
      rdc(IDX_PKTCTL, 32'h0);
      rdc(IDX_SET, 32'h0);
      rdc(IDX_CLR, 32'h0);
      rdc(6'h3F, 32'h0);
      rdc(IDX_IRQ_STAT, 32'h0);
      // Pin 3 belongs to an alternate function
      {alt_sel_i, alt_o_i, alt_oe_i} <= {10'h008, 10'h3FF, 10'h008};
      wr(IDX_DIR, 32'hFC0F);
      rdc(IDX_DIR, 32'h00F);
      wr(IDX_SET, 32'h3FF);
      chk("pin_oe", pin_oe, 32'h00F);
      chk("pin_o", pin_o, 32'h00F);
      wr(IDX_CLR, 32'h005);
      chk("pin_o", pin_o, 32'h00A);
      wr(IDX_LEVEL, 32'h001);
      chk("pin_o", pin_o, 32'h009);
      wr(IDX_DIR, 32'h0);
      wr(IDX_IRQ_EN, 32'h7);
      // Standard packet from a pin change, errors latched before it
      {ring_i, dsr_i, dcd_i} <= 3'b110;
      evt(4'b0110);
      pin_i <= 10'h001;
      exp_q = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h6A, 8'h00};
      chk_pkt();
      rdc(IDX_LEVEL, 32'h001);
      rdc(IDX_IRQ_STAT, 32'h5);
      chk("irq", irq_o, 32'h1);
      wr(IDX_IRQ_CLR, 32'h7);
      chk("irq", irq_o, 32'h0);
      // Vendor packet, slow host, masked pin 8 ignored
      wr(IDX_PKTCTL, 32'h1);
      slow <= 1'b1;
      pin_i <= 10'h101;
      nopkt();
      evt(4'b0001);
      pin_i <= 10'h301;
      exp_q = '{8'h01, 8'h03, 8'h00, 8'h02, 8'h02};
      chk_pkt();
      wr(IDX_IRQ_CLR, 32'h7);
      // Break with notify off, then on
      evt(4'b1000);
      nopkt();
      rdc(IDX_IRQ_STAT, 32'h2);
      wr(IDX_PKTCTL, 32'h3);
      evt(4'b1000);
      exp_q = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h01};
      chk_pkt();
      wr(IDX_MASK, 32'h0);
      pin_i <= 10'h201;
      exp_q = '{8'h01, 8'h02, 8'h00, 8'h01, 8'h00};
      chk_pkt();
      give_verdict();
   end
endmodule
bind pcn_pin_notify pcn_sva u_sva (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o), .pin_oe(pin_oe),
   .alt_sel_i(alt_sel_i), .alt_o_i(alt_o_i), .alt_oe_i(alt_oe_i),
   .pkt_valid_o(pkt_valid_o), .pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o),
   .pkt_ready_i(pkt_ready_i), .irq_o(irq_o));
`default_nettype wire
